/* File: logic/psr_readout.sv */
// pressure sensor readout: scheduling, result registers, shadowing
// assumes classic wishbone on mclk; serial front end reports burst end
// by chip_select_active_low and a one-cycle i2c_stop pulse
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module psr_readout
  import psr_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic chip_select_active_low,
  input wire logic i2c_stop,
  input wire psr_result_t adc_result,
  output logic measuring
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] mode;
    logic [2:0] osrs_p;
    logic [2:0] osrs_t;
    logic [2:0] standby_code;
    logic pend;
    logic [1:0] pend_mode;
    psr_phase_t phase;
    logic [15:0] remain;
    psr_result_t vis;
    psr_result_t shd;
    logic shd_full;
    logic burst;
    logic cs_prev;
    logic measuring;
  } psr_state_t;

  psr_state_t r;
  psr_state_t next_r;
  psr_wb_req_t req;
  logic tick;
  logic bus_req;
  logic [7:0] idx;
  logic in_map;
  logic is_result;
  logic burst_end;
  logic conv_done;
  logic [2:0] lvl;
  logic [7:0] rbyte;

  // ==========================================================
  // timebase
  psr_tick #(.PERIOD(TICK_PERIOD)) u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tick)
  );

  // ==========================================================
  // bus request decode
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
  assign bus_req = req.cyc & req.stb & ~r.ack;
  assign idx = req.adr[9:2];
  assign in_map = (req.adr[11:10] == 2'h0);
  assign is_result = in_map && idx >= IDX_TEMP_MSB
                     && idx <= IDX_PRESS_LOW;
  assign burst_end = (chip_select_active_low & ~r.cs_prev) | i2c_stop;
  assign conv_done = (r.phase == PH_MEASURE) && tick
                     && (r.remain == 16'h1);
  assign lvl = (psr_level(r.osrs_p) > psr_level(r.osrs_t))
               ? psr_level(r.osrs_p) : psr_level(r.osrs_t);

  // ==========================================================
  // read mux, result bytes packed high first
  always_comb
  begin
    rbyte = 8'h0;
    // msb, mid, low nibble on top
    if (idx == IDX_TEMP_MSB)
      rbyte = r.vis.temp[19:12];
    else if (idx == IDX_TEMP_MID)
      rbyte = r.vis.temp[11:4];
    else if (idx == IDX_TEMP_LOW)
      rbyte = {r.vis.temp[3:0], 4'h0};
    else if (idx == IDX_PRESS_MSB)
      rbyte = r.vis.press[19:12];
    else if (idx == IDX_PRESS_MID)
      rbyte = r.vis.press[11:4];
    else if (idx == IDX_PRESS_LOW)
      rbyte = {r.vis.press[3:0], 4'h0};
    else if (idx == IDX_CTRL)
      rbyte = {r.osrs_t, r.osrs_p, r.mode};
    else if (idx == IDX_CONFIG)
      rbyte = {r.standby_code, 5'h0};
    else if (idx == IDX_STATUS)
    begin
      rbyte[STATUS_MEASURING_BIT] = r.measuring;
      rbyte[STATUS_SHADOW_BIT] = r.shd_full;
    end
    if (!in_map)
      rbyte = 8'h0;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.cs_prev = chip_select_active_low;

    // bus slave: one wait state, unmapped reads as zero
    if (bus_req)
    begin
      next_r.ack = 1'b1;
      next_r.rdata = {24'h0, rbyte};
      if (req.we && req.sel[0] && in_map)
      begin
        if (idx == IDX_CTRL)
        begin
          next_r.osrs_p = req.dat[CTRL_OSRS_P_LSB +: 3];
          next_r.osrs_t = req.dat[CTRL_OSRS_T_LSB +: 3];
          if (r.phase == PH_MEASURE)
          begin
            if (!r.pend)
            begin
              next_r.pend = 1'b1;
              next_r.pend_mode = req.dat[CTRL_MODE_LSB +: 2];
            end
          end
          else
          begin
            next_r.mode = req.dat[CTRL_MODE_LSB +: 2];
          end
        end
        else if (idx == IDX_CONFIG)
        begin
          next_r.standby_code = req.dat[CONFIG_SB_LSB +: 3];
        end
      end
    end

    // burst tracking; a stop closes it before a new read reopens
    if (burst_end)
      next_r.burst = 1'b0;
    if (bus_req && !req.we && is_result)
      next_r.burst = 1'b1;

    if (conv_done)
    begin
      if (r.burst && !burst_end)
      begin
        next_r.shd = adc_result;
        next_r.shd_full = 1'b1;
      end
      else
      begin
        next_r.vis = adc_result;
        next_r.shd_full = 1'b0;
      end
    end
    else if (burst_end && r.shd_full)
    begin
      next_r.vis = r.shd;
      next_r.shd_full = 1'b0;
    end

    // measurement sequencer
    case (r.phase)
      PH_IDLE:
      begin
        // any non-sleep code starts a conversion
        if (r.mode != MODE_SLEEP)
        begin
          next_r.phase = PH_MEASURE;
          next_r.remain = psr_conv_ticks(lvl);
          next_r.measuring = 1'b1;
        end
      end
      PH_MEASURE:
      begin
        if (tick)
          next_r.remain = r.remain - 16'h1;
        if (conv_done)
        begin
          next_r.measuring = 1'b0;
          if (next_r.pend)
          begin
            next_r.mode = next_r.pend_mode;
            next_r.pend = 1'b0;
            next_r.phase = PH_IDLE;
          end
          else if (r.mode == MODE_NORMAL)
          begin
            next_r.phase = PH_STANDBY;
            next_r.remain = psr_sb_ticks(r.standby_code);
          end
          else
          begin
            next_r.mode = MODE_SLEEP;
            next_r.phase = PH_IDLE;
          end
        end
      end
      PH_STANDBY:
      begin
        // a mode write during standby acts at once
        if (r.mode != MODE_NORMAL)
          next_r.phase = PH_IDLE;
        else if (tick)
        begin
          if (r.remain == 16'h1)
          begin
            next_r.phase = PH_MEASURE;
            next_r.remain = psr_conv_ticks(lvl);
            next_r.measuring = 1'b1;
          end
          else
          begin
            next_r.remain = r.remain - 16'h1;
          end
        end
      end
      default:
      begin
        next_r.phase = PH_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register, reset values from the package
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.mode <= MODE_RESET;
      r.osrs_p <= OSRS_RESET;
      r.osrs_t <= OSRS_RESET;
      r.standby_code <= SB_RESET;
      r.phase <= PH_IDLE;
      r.cs_prev <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdata;
  assign measuring = r.measuring;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_done_in_burst;
    conv_done && r.burst && !burst_end;
  endsequence
  sequence s_end_with_shadow;
    burst_end && r.shd_full && !conv_done;
  endsequence

  property p_shadow_park;
    s_done_in_burst |=> $stable(r.vis) && r.shd_full;
  endproperty
  a_shadow_park: assert property (p_shadow_park)
    else $error("result changed during burst");

  property p_shadow_copy;
    s_end_with_shadow |=> r.vis == $past(r.shd) && !r.shd_full;
  endproperty
  a_shadow_copy: assert property (p_shadow_copy)
    else $error("shadow not copied at burst end");

  property p_forced_sleep;
    conv_done && !next_r.pend && r.mode != MODE_NORMAL
      |=> r.mode == MODE_SLEEP && r.phase == PH_IDLE;
  endproperty
  a_forced_sleep: assert property (p_forced_sleep)
    else $error("single-shot did not return to sleep");

  property p_mode_hold;
    r.phase == PH_MEASURE && !conv_done |=> $stable(r.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed mid conversion");

  property p_sleep_idle;
    r.phase == PH_IDLE && r.mode == MODE_SLEEP |=> !r.measuring;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle)
    else $error("conversion started in sleep");

  property p_conv_len;
    $rose(r.measuring) |-> r.remain == psr_conv_ticks($past(lvl));
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("wrong conversion length");

  property p_sb_len;
    $rose(r.phase == PH_STANDBY)
      |-> r.remain == psr_sb_ticks($past(r.standby_code));
  endproperty
  a_sb_len: assert property (p_sb_len)
    else $error("wrong standby length");

  property p_low_nibble;
    bus_req && !req.we && (idx == IDX_TEMP_LOW || idx == IDX_PRESS_LOW)
      |=> r.ack && r.rdata[3:0] == 4'h0 && r.rdata[31:8] == 24'h0;
  endproperty
  a_low_nibble: assert property (p_low_nibble)
    else $error("low result byte malformed");

  property p_ack_pulse;
    r.ack |=> !r.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

endmodule : psr_readout

/* File: logic/psr_pkg.sv */
// pressure sensor readout: shared constants, types and timing
// assumes a 100 MHz mclk and a 32-bit classic wishbone register bus
package psr_pkg;

  // ==========================================================
  // clock and timebase
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'hf3;
  localparam logic [7:0] IDX_CTRL = 8'hf4;
  localparam logic [7:0] IDX_CONFIG = 8'hf5;
  localparam logic [7:0] IDX_TEMP_MSB = 8'hf7;
  localparam logic [7:0] IDX_TEMP_MID = 8'hf8;
  localparam logic [7:0] IDX_TEMP_LOW = 8'hf9;
  localparam logic [7:0] IDX_PRESS_MSB = 8'hfa;
  localparam logic [7:0] IDX_PRESS_MID = 8'hfb;
  localparam logic [7:0] IDX_PRESS_LOW = 8'hfc;

  // ==========================================================
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OSRS_P_LSB = 2;
  localparam int CTRL_OSRS_T_LSB = 5;
  localparam int CONFIG_SB_LSB = 5;
  localparam int STATUS_SHADOW_BIT = 0;
  localparam int STATUS_MEASURING_BIT = 3;

  // ==========================================================
  // reset values
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] OSRS_RESET = 3'h0;
  localparam logic [2:0] SB_RESET = 3'h0;

  // power state codes
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  // ==========================================================
  // longest conversion time per oversampling level, microseconds
  localparam int CONV_MAX_US_L0 = 6400;
  localparam int CONV_MAX_US_L1 = 8700;
  localparam int CONV_MAX_US_L2 = 13300;
  localparam int CONV_MAX_US_L3 = 22500;
  localparam int CONV_MAX_US_L4 = 43200;
  // standby intervals, microseconds
  localparam int SB_US_0 = 500;
  localparam int SB_US_1 = 62500;
  localparam int SB_US_2 = 125000;
  localparam int SB_US_3 = 250000;
  localparam int SB_US_4 = 500000;
  localparam int SB_US_5 = 1000000;
  localparam int SB_US_6 = 2000000;
  localparam int SB_US_7 = 4000000;

  typedef enum logic [1:0] {PH_IDLE, PH_MEASURE, PH_STANDBY} psr_phase_t;

  // one pressure and temperature sample
  typedef struct packed {
    logic [19:0] press;
    logic [19:0] temp;
  } psr_result_t;

  // classic wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } psr_wb_req_t;

  // oversampling code to level 0..4, skipped counts as lowest
  function automatic logic [2:0] psr_level(input logic [2:0] osrs);
    logic [2:0] lvl;
    lvl = 3'h4;
    if (osrs <= 3'h1) lvl = 3'h0;
    else if (osrs == 3'h2) lvl = 3'h1;
    else if (osrs == 3'h3) lvl = 3'h2;
    else if (osrs == 3'h4) lvl = 3'h3;
    return lvl;
  endfunction : psr_level

  // longest conversion in ticks; floor division is exact, each time is a whole number of ticks
  function automatic logic [15:0] psr_conv_ticks(input logic [2:0] lvl);
    int us;
    case (lvl)
      3'h0: us = CONV_MAX_US_L0;
      3'h1: us = CONV_MAX_US_L1;
      3'h2: us = CONV_MAX_US_L2;
      3'h3: us = CONV_MAX_US_L3;
      default: us = CONV_MAX_US_L4;
    endcase
    return 16'(us / TICK_US);
  endfunction : psr_conv_ticks

  function automatic logic [15:0] psr_sb_ticks(input logic [2:0] code);
    int us;
    case (code)
      3'h0: us = SB_US_0;
      3'h1: us = SB_US_1;
      3'h2: us = SB_US_2;
      3'h3: us = SB_US_3;
      3'h4: us = SB_US_4;
      3'h5: us = SB_US_5;
      3'h6: us = SB_US_6;
      default: us = SB_US_7;
    endcase
    return 16'(us / TICK_US);
  endfunction : psr_sb_ticks

endpackage : psr_pkg

/* File: logic/psr_tick.sv */
// pressure sensor readout: timebase divider
// assumes one mclk domain; emits a one-cycle enable every period
`timescale 1ns/1ps
module psr_tick
  import psr_pkg::*;
#(
  parameter int PERIOD = TICK_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_b,
  output logic tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } psr_tick_state_t;

  psr_tick_state_t r;
  psr_tick_state_t next_r;

  // ==========================================================
  // divider: count down, pulse on wrap
  always_comb
  begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt == 16'h0)
    begin
      next_r.cnt = 16'(PERIOD - 1);
      next_r.tick = 1'b1;
    end
    else
    begin
      next_r.cnt = r.cnt - 16'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick = r.tick;

endmodule : psr_tick

/* File: tb/psr_host_link.sv */
// host side of the serial link: drives select level and stop pulse
// assumes one mclk domain; the bench calls the tasks below
`timescale 1ns/1ps
module psr_host_link
(
  input wire logic mclk,
  output logic chip_select_active_low,
  output logic i2c_stop
);
  // ==========================================================
  // idle levels: select released, no stop
  initial
  begin
    chip_select_active_low = 1'b1;
    i2c_stop = 1'b0;
  end

  task automatic spi_select();
    @(posedge mclk);
    chip_select_active_low <= 1'b0;
  endtask : spi_select

  task automatic spi_release();
    @(posedge mclk);
    chip_select_active_low <= 1'b1;
  endtask : spi_release

  task automatic i2c_end();
    @(posedge mclk);
    i2c_stop <= 1'b1;
    @(posedge mclk);
    i2c_stop <= 1'b0;
  endtask : i2c_end
endmodule : psr_host_link

/* File: tb/psr_readout_tb.sv */
// self-checking bench for the result readout block
// assumes TICK_PERIOD of 10 cycles, so one tick is 0.1 ms scaled down
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module psr_readout_tb
  import psr_pkg::*;
();
  localparam int TP = 10;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [11:0] adr = 12'h0;
  logic [31:0] dat = 32'h0;
  logic ack;
  logic [31:0] rdat;
  logic cs_b;
  logic stop;
  logic meas;
  psr_result_t adc = '0;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] q;
  int n;

  // ==========================================================
  // clock, device and host link
  always #5 mclk = ~mclk;
  psr_readout #(.TICK_PERIOD(TP)) dut_u (.mclk(mclk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .chip_select_active_low(cs_b), .i2c_stop(stop), .adc_result(adc),
    .measuring(meas));
  psr_host_link link_u (.mclk(mclk), .chip_select_active_low(cs_b),
    .i2c_stop(stop));

  // ==========================================================
  // verdict and shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // a bounded wait ran out: counts as a mismatch and ends the run
  task automatic fail_wait(input string nm);
    n_mismatch++;
    $display("ERROR wait %s expected done seen timeout", nm);
    summarize();
  endtask : fail_wait

  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx,
    input logic [7:0] d, output logic [31:0] rq);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {2'h0, idx, 2'h0};
    dat <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
      fail_wait("ack");
  endtask : wb

  task automatic wait_meas(input logic lvl, input int lim, output int c);
    c = 0;
    while (meas !== lvl && c < lim)
    begin
      @(posedge mclk);
      c++;
    end
    if (meas !== lvl)
      fail_wait("measuring");
  endtask : wait_meas

  // six result bytes in address order, read as one burst
  task automatic rd_res(input psr_result_t r);
    logic [31:0] rq;
    logic [7:0] e [6];
    e = '{r.temp[19:12], r.temp[11:4], {r.temp[3:0], 4'h0},
      r.press[19:12], r.press[11:4], {r.press[3:0], 4'h0}};
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b0, IDX_TEMP_MSB + 8'(i), 8'h0, rq);
      `CHK("result byte", {24'h0, e[i]}, rq)
    end
  endtask : rd_res

  // ==========================================================
  // scenarios
  task automatic t_reset();
    link_u.spi_select();
    wb(1'b0, IDX_CTRL, 8'h0, q);
    `CHK("ctrl reset", 32'h0, q)
    `CHK("idle after reset", 1'b0, meas)
    wb(1'b1, IDX_TEMP_MSB, 8'hff, q);
    rd_res('0);
    wb(1'b0, 8'h10, 8'h0, q);
    `CHK("unmapped read", 32'h0, q)
    link_u.spi_release();
    $display("test reset done");
  endtask : t_reset

  // single shot: length from the slower oversampling, then back to sleep
  task automatic t_single(input logic [7:0] ctrl, input int ticks,
    input psr_result_t r);
    adc <= r;
    wb(1'b1, IDX_CTRL, ctrl, q);
    wait_meas(1'b1, 20, n);
    wait_meas(1'b0, ticks * TP + 20, n);
    `CHK("conv length", 1'b1, n >= (ticks-1)*TP && n <= ticks*TP+2)
    link_u.spi_select();
    rd_res(r);
    link_u.spi_release();
    wb(1'b0, IDX_CTRL, 8'h0, q);
    `CHK("mode after shot", {24'h0, ctrl & 8'hfc}, q)
    repeat (200) @(posedge mclk);
    `CHK("stays asleep", 1'b0, meas)
    $display("test single shot done");
  endtask : t_single

  // continuous cycling, standby codes, shadowing on both burst ends
  task automatic t_cont();
    adc <= 40'habcde12345;
    wb(1'b1, IDX_CONFIG, 8'h00, q);
    wb(1'b1, IDX_CTRL, 8'h07, q);
    wait_meas(1'b1, 20, n);
    wait_meas(1'b0, 700, n);
    wait_meas(1'b1, 100, n);
    `CHK("standby 0", 1'b1, n >= 4*TP && n <= 5*TP+3)
    wb(1'b1, IDX_CONFIG, 8'h20, q);
    wait_meas(1'b0, 700, n);
    wait_meas(1'b1, 6400, n);
    `CHK("standby 1", 1'b1, n >= 624*TP && n <= 625*TP+3)
    link_u.spi_select();
    wb(1'b0, IDX_PRESS_LOW, 8'h0, q);
    adc <= 40'h0f1e29a8b7;
    wait_meas(1'b0, 700, n);
    wb(1'b0, IDX_TEMP_MSB, 8'h0, q);
    `CHK("visible held", 32'h12, q)
    wb(1'b0, IDX_STATUS, 8'h0, q);
    `CHK("shadow flag", 1'b1, q[STATUS_SHADOW_BIT])
    link_u.spi_release();
    repeat (3) @(posedge mclk);
    rd_res(40'h0f1e29a8b7);
    wb(1'b0, IDX_STATUS, 8'h0, q);
    `CHK("shadow clear", 1'b0, q[STATUS_SHADOW_BIT])
    wait_meas(1'b1, 6400, n);
    adc <= 40'h55aa33c5a6;
    wait_meas(1'b0, 700, n);
    wb(1'b0, IDX_PRESS_MSB, 8'h0, q);
    `CHK("visible held", 32'h0f, q)
    link_u.i2c_end();
    repeat (3) @(posedge mclk);
    rd_res(40'h55aa33c5a6);
    link_u.i2c_end();
    $display("test continuous done");
  endtask : t_cont

  // sleep asked mid conversion waits; the next request is dropped
  task automatic t_pending();
    wb(1'b1, IDX_CONFIG, 8'h00, q);
    wait_meas(1'b1, 6400, n);
    wait_meas(1'b0, 700, n);
    wait_meas(1'b1, 100, n);
    wb(1'b1, IDX_CTRL, 8'h04, q);
    wb(1'b1, IDX_CTRL, 8'h07, q);
    `CHK("still measuring", 1'b1, meas)
    wb(1'b0, IDX_STATUS, 8'h0, q);
    `CHK("status busy", 1'b1, q[STATUS_MEASURING_BIT])
    wait_meas(1'b0, 700, n);
    repeat (200) @(posedge mclk);
    `CHK("asleep after", 1'b0, meas)
    wb(1'b0, IDX_CTRL, 8'h0, q);
    `CHK("mode sleep", 2'h0, q[1:0])
    $display("test pending mode done");
  endtask : t_pending

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_single(8'h05, 64, 40'h0123456789);
    t_single(8'h0e, 133, 40'hfedcba9876);
    t_single(8'ha1, 432, 40'h13579bdf02);
    t_cont();
    t_pending();
    summarize();
  end
endmodule : psr_readout_tb
